/* File: common/cesa_pkg.sv */
// constants, types and the frame layout shared by both ends of the serial access port
package cesa_pkg;
  localparam int PREAMBLE_LEN    = 32;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_CLEAR   = 2'h1;
  localparam int ADDR_W          = 7;
  localparam int DATA_W          = 32;
  localparam int WORD_W          = 16;
  localparam int IDX_W           = 7;
  localparam int DEV_W           = 2;
  localparam int NPORTS          = 6;
  localparam int TA_LEN          = 2;
  localparam int IDLE_CLOCKS     = 2;
  localparam int RD_FIELD_BITS   = 1 + ADDR_W;
  localparam int CLR_FIELD_BITS  = DEV_W + 1 + IDX_W;
  localparam int RD_HDR_LEN      = PREAMBLE_LEN + 4 + RD_FIELD_BITS;
  localparam int CLR_HDR_LEN     = PREAMBLE_LEN + 4 + CLR_FIELD_BITS;
  localparam int RD_DATA_FIRST   = RD_HDR_LEN + TA_LEN;
  localparam int RD_FRAME_LEN    = RD_DATA_FIRST + DATA_W + IDLE_CLOCKS;
  localparam int CLR_FRAME_LEN   = CLR_HDR_LEN + IDLE_CLOCKS;
  localparam int HDR_W           = 48;
  // timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int LINK_PERIOD_NS  = 800;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // host register map
  localparam logic [4:0] REG_CMD      = 5'h00;
  localparam logic [4:0] REG_STATUS   = 5'h04;
  localparam logic [4:0] REG_RESULT   = 5'h08;
  localparam logic [4:0] REG_INT_STAT = 5'h0C;
  localparam logic [4:0] REG_INT_MASK = 5'h10;
  localparam int CMD_ARG_LSB     = 0;
  localparam int CMD_SEL_BIT     = 7;
  localparam int CMD_DEV_LSB     = 8;
  localparam int CMD_OP_BIT      = 16;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int INT_RD_DONE     = 0;
  localparam int INT_CLR_DONE    = 1;
  localparam logic [31:0] CMD_RESET      = 32'h0;
  localparam logic [1:0]  INT_MASK_RESET = 2'h0;
  localparam logic [5:0]  OVF_RESET      = 6'h0;

  typedef enum logic [6:0] {
    DEV_HUNT  = 7'h01,
    DEV_START = 7'h02,
    DEV_OP    = 7'h04,
    DEV_RADDR = 7'h08,
    DEV_CLR   = 7'h10,
    DEV_TURN  = 7'h20,
    DEV_DATA  = 7'h40
  } cesa_dev_state_type;
endpackage

/* File: common/cesa_link_if.sv */
// serial access link between management host and switch device
`timescale 1ns/100ps
interface cesa_link_if;
  logic serial_port_clock;
  logic serial_port_select;
  logic host_data_out;
  logic host_data_oe;
  logic dev_data_out;
  logic dev_data_oe;
  logic serial_port_data_line;

  // pulled high when nobody drives
  assign serial_port_data_line = host_data_oe ? host_data_out :
                                 dev_data_oe  ? dev_data_out  : 1'b1;

  modport host_end (
    output serial_port_clock,
    output serial_port_select,
    output host_data_out,
    output host_data_oe,
    input  serial_port_data_line
  );
  modport dev_end (
    input  serial_port_clock,
    input  serial_port_select,
    input  serial_port_data_line,
    output dev_data_out,
    output dev_data_oe
  );
endinterface

/* File: rtl/cesa_dev_end.sv */
// switch-side end: decodes read and clear frames, returns counter or memory words
`timescale 1ns/100ps
module cesa_dev_end (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        ce,
  cesa_link_if.dev_end     link,
  input  wire logic [1:0]  strapped_chip_address,
  input  wire logic [31:0] cnt_data,
  input  wire logic [15:0] mem_data_hi,
  input  wire logic [15:0] mem_data_lo,
  input  wire logic [5:0]  col_ovf_event,
  input  wire logic [5:0]  err_ovf_event,
  output logic [6:0]       cnt_addr,
  output logic [6:0]       mem_addr_hi,
  output logic [6:0]       mem_addr_lo,
  output logic             rd_strobe,
  output logic             clr_req,
  output logic             clr_all,
  output logic [6:0]       clr_index,
  output logic [5:0]       col_ovf,
  output logic [5:0]       err_ovf
);
  logic [2:0]  sck_sync;
  logic [1:0]  sel_sync;
  logic [1:0]  dat_sync;
  logic [2:0]  next_sck_sync;
  logic [1:0]  next_sel_sync;
  logic [1:0]  next_dat_sync;

  cesa_pkg::cesa_dev_state_type state;
  cesa_pkg::cesa_dev_state_type next_state;
  logic [5:0]  pre_cnt;
  logic [5:0]  next_pre_cnt;
  logic [5:0]  bit_cnt;
  logic [5:0]  next_bit_cnt;
  logic [31:0] shreg;
  logic [31:0] next_shreg;
  logic        tbl;
  logic        next_tbl;
  logic        dout;
  logic        next_dout;
  logic        doe;
  logic        next_doe;
  // strap pins pass two flops, the compare reads the second
  logic [3:0]  strap;
  logic [3:0]  next_strap;
  logic [6:0]  next_cnt_addr;
  logic [6:0]  next_mem_addr_hi;
  logic [6:0]  next_mem_addr_lo;
  logic        next_rd_strobe;
  logic        next_clr_req;
  logic        next_clr_all;
  logic [6:0]  next_clr_index;
  logic [5:0]  next_col_ovf;
  logic [5:0]  next_err_ovf;
  logic        rise;
  logic        din;

  function automatic logic [5:0] port_mask(input logic [6:0] idx);
    logic [5:0] m;
    m = '0;
    for (int i = 0; i < cesa_pkg::NPORTS; i++) begin
      if (idx == 7'(i)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  always_comb begin
    next_sck_sync = {sck_sync[1:0], link.serial_port_clock};
    next_sel_sync = {sel_sync[0], link.serial_port_select};
    next_dat_sync = {dat_sync[0], link.serial_port_data_line};
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_sync <= 3'h0;
      sel_sync <= 2'h3;
      dat_sync <= 2'h3;
    end else if (ce) begin
      sck_sync <= next_sck_sync;
      sel_sync <= next_sel_sync;
      dat_sync <= next_dat_sync;
    end
  end

  assign rise = sck_sync[1] & ~sck_sync[2];
  assign din  = dat_sync[1];

  always_comb begin
    logic [9:0] f;
    logic [5:0] clr_mask;
    f                = {shreg[8:0], din};
    clr_mask         = '0;
    next_state       = state;
    next_pre_cnt     = pre_cnt;
    next_bit_cnt     = bit_cnt;
    next_shreg       = shreg;
    next_tbl         = tbl;
    next_dout        = dout;
    next_doe         = doe;
    next_strap       = {strap[1:0], strapped_chip_address};
    next_cnt_addr    = cnt_addr;
    next_mem_addr_hi = mem_addr_hi;
    next_mem_addr_lo = mem_addr_lo;
    next_rd_strobe   = 1'b0;
    next_clr_req     = 1'b0;
    next_clr_all     = clr_all;
    next_clr_index   = clr_index;
    if (sel_sync[1]) begin
      // select high aborts any frame and frees the line
      next_state   = cesa_pkg::DEV_HUNT;
      next_pre_cnt = '0;
      next_doe     = 1'b0;
    end else if (rise) begin
      case (state)
        cesa_pkg::DEV_HUNT: begin
          if (din) begin
            if (pre_cnt != 6'(cesa_pkg::PREAMBLE_LEN)) begin
              next_pre_cnt = pre_cnt + 6'h01;
            end
          end else begin
            if (pre_cnt == 6'(cesa_pkg::PREAMBLE_LEN)) begin
              next_state = cesa_pkg::DEV_START;
            end
            next_pre_cnt = '0;
          end
        end
        cesa_pkg::DEV_START: begin
          next_bit_cnt = '0;
          next_state   = din ? cesa_pkg::DEV_OP : cesa_pkg::DEV_HUNT;
        end
        cesa_pkg::DEV_OP: begin
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == 6'h01) begin
            next_bit_cnt = '0;
            if (f[1:0] == cesa_pkg::OP_READ) begin
              next_state = cesa_pkg::DEV_RADDR;
            end else if (f[1:0] == cesa_pkg::OP_CLEAR) begin
              next_state = cesa_pkg::DEV_CLR;
            end else begin
              next_state = cesa_pkg::DEV_HUNT;
            end
          end
          next_shreg = {shreg[30:0], din};
        end
        cesa_pkg::DEV_RADDR: begin
          next_shreg   = {shreg[30:0], din};
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == 6'(cesa_pkg::RD_FIELD_BITS - 1)) begin
            next_tbl         = f[7];
            next_cnt_addr    = f[6:0];
            next_mem_addr_hi = {f[6:1], 1'b1};
            next_mem_addr_lo = {f[6:1], 1'b0};
            next_rd_strobe   = 1'b1;
            next_bit_cnt     = '0;
            next_state       = cesa_pkg::DEV_TURN;
          end
        end
        cesa_pkg::DEV_TURN: begin
          if (bit_cnt == 6'h00) begin
            // first turnaround bit: take the line, drive zero
            next_shreg   = tbl ? cnt_data : {mem_data_hi, mem_data_lo};
            next_doe     = 1'b1;
            next_dout    = 1'b0;
            next_bit_cnt = 6'h01;
          end else begin
            next_dout    = shreg[31];
            next_shreg   = {shreg[30:0], 1'b0};
            next_bit_cnt = '0;
            next_state   = cesa_pkg::DEV_DATA;
          end
        end
        cesa_pkg::DEV_DATA: begin
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == 6'(cesa_pkg::DATA_W - 1)) begin
            next_doe     = 1'b0;
            next_pre_cnt = '0;
            next_state   = cesa_pkg::DEV_HUNT;
          end else begin
            next_dout  = shreg[31];
            next_shreg = {shreg[30:0], 1'b0};
          end
        end
        cesa_pkg::DEV_CLR: begin
          next_shreg   = {shreg[30:0], din};
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == 6'(cesa_pkg::CLR_FIELD_BITS - 1)) begin
            if (f[9:8] == strap[3:2]) begin
              next_clr_req   = 1'b1;
              next_clr_all   = f[7];
              next_clr_index = f[6:0];
              if (f[7]) begin
                clr_mask = port_mask(f[6:0]);
              end
            end
            next_pre_cnt = '0;
            next_state   = cesa_pkg::DEV_HUNT;
          end
        end
        default: begin
          next_state   = cesa_pkg::DEV_HUNT;
          next_pre_cnt = '0;
          next_doe     = 1'b0;
        end
      endcase
    end
    // a new overflow wins over a port clear in the same cycle
    next_col_ovf = (col_ovf & ~clr_mask) | col_ovf_event;
    next_err_ovf = (err_ovf & ~clr_mask) | err_ovf_event;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state       <= cesa_pkg::DEV_HUNT;
      pre_cnt     <= '0;
      bit_cnt     <= '0;
      shreg       <= '0;
      tbl         <= 1'b0;
      dout        <= 1'b0;
      doe         <= 1'b0;
      strap       <= '0;
      cnt_addr    <= '0;
      mem_addr_hi <= '0;
      mem_addr_lo <= '0;
      rd_strobe   <= 1'b0;
      clr_req     <= 1'b0;
      clr_all     <= 1'b0;
      clr_index   <= '0;
      col_ovf     <= cesa_pkg::OVF_RESET;
      err_ovf     <= cesa_pkg::OVF_RESET;
    end else if (ce) begin
      state       <= next_state;
      pre_cnt     <= next_pre_cnt;
      bit_cnt     <= next_bit_cnt;
      shreg       <= next_shreg;
      tbl         <= next_tbl;
      dout        <= next_dout;
      doe         <= next_doe;
      strap       <= next_strap;
      cnt_addr    <= next_cnt_addr;
      mem_addr_hi <= next_mem_addr_hi;
      mem_addr_lo <= next_mem_addr_lo;
      rd_strobe   <= next_rd_strobe;
      clr_req     <= next_clr_req;
      clr_all     <= next_clr_all;
      clr_index   <= next_clr_index;
      col_ovf     <= next_col_ovf;
      err_ovf     <= next_err_ovf;
    end
  end

  assign link.dev_data_out = dout;
  assign link.dev_data_oe  = doe;
endmodule

/* File: rtl/cesa_host_end.sv */
// management-host end: builds read and clear frames from software commands
`timescale 1ns/100ps
module cesa_host_end (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        ce,
  cesa_link_if.host_end    link,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq
);
  localparam int HW = cesa_pkg::HDR_W - 1;
  logic [1:0]  dat_sync;
  logic [1:0]  div;
  logic        sck;
  logic        sel;
  logic        hdo;
  logic        hoe;
  logic        busy;
  logic        is_read;
  logic [6:0]  bitn;
  logic [HW:0] hdr;
  logic [31:0] rx;
  logic [31:0] cmd;
  logic [31:0] result;
  logic [1:0]  int_stat;
  logic [1:0]  int_mask;
  logic [1:0]  next_dat_sync;
  logic [1:0]  next_div;
  logic        next_sck;
  logic        next_sel;
  logic        next_hdo;
  logic        next_hoe;
  logic        next_busy;
  logic        next_is_read;
  logic [6:0]  next_bitn;
  logic [HW:0] next_hdr;
  logic [31:0] next_rx;
  logic [31:0] next_cmd;
  logic [31:0] next_result;
  logic [1:0]  next_int_stat;
  logic [1:0]  next_int_mask;
  logic [31:0] next_reg_rdata;
  logic        next_irq;

  always_comb begin
    logic [1:0]  ev;
    logic [HW:0] h;
    logic [6:0]  nb;
    ev             = '0;
    h              = '0;
    nb             = bitn + 7'h01;
    next_dat_sync  = {dat_sync[0], link.serial_port_data_line};
    next_div       = div;
    next_sck       = sck;
    next_sel       = sel;
    next_hdo       = hdo;
    next_hoe       = hoe;
    next_busy      = busy;
    next_is_read   = is_read;
    next_bitn      = bitn;
    next_hdr       = hdr;
    next_rx        = rx;
    next_cmd       = cmd;
    next_result    = result;
    next_int_mask  = int_mask;
    next_reg_rdata = '0;
    if (reg_wr && reg_addr == cesa_pkg::REG_CMD && !busy) begin
      next_cmd     = reg_wdata;
      next_is_read = !reg_wdata[cesa_pkg::CMD_OP_BIT];
      if (reg_wdata[cesa_pkg::CMD_OP_BIT]) begin
        h = {{cesa_pkg::PREAMBLE_LEN{1'b1}}, cesa_pkg::START_CODE, cesa_pkg::OP_CLEAR,
             reg_wdata[cesa_pkg::CMD_DEV_LSB +: cesa_pkg::DEV_W],
             reg_wdata[cesa_pkg::CMD_SEL_BIT],
             reg_wdata[cesa_pkg::CMD_ARG_LSB +: cesa_pkg::IDX_W], 2'h0};
      end else begin
        h = {{cesa_pkg::PREAMBLE_LEN{1'b1}}, cesa_pkg::START_CODE, cesa_pkg::OP_READ,
             reg_wdata[cesa_pkg::CMD_SEL_BIT],
             reg_wdata[cesa_pkg::CMD_ARG_LSB +: cesa_pkg::ADDR_W], 4'h0};
      end
      next_hdo  = h[HW];
      next_hdr  = {h[HW-1:0], 1'b0};
      next_hoe  = 1'b1;
      next_sel  = 1'b0;
      next_sck  = 1'b0;
      next_div  = '0;
      next_bitn = '0;
      next_busy = 1'b1;
    end else if (busy) begin
      next_div = div + 2'h1;
      if (div == 2'(cesa_pkg::LINK_HALF_CYCLES - 1)) begin
        next_div = '0;
        next_sck = ~sck;
        if (!sck) begin
          // rising edge: sample returned data
          if (is_read && bitn >= 7'(cesa_pkg::RD_DATA_FIRST)
              && bitn < 7'(cesa_pkg::RD_DATA_FIRST + cesa_pkg::DATA_W)) begin
            next_rx = {rx[30:0], dat_sync[1]};
          end
        end else begin
          // falling edge: move to the next bit
          next_bitn = nb;
          if (nb == (is_read ? 7'(cesa_pkg::RD_FRAME_LEN) : 7'(cesa_pkg::CLR_FRAME_LEN))) begin
            next_busy = 1'b0;
            next_sel  = 1'b1;
            next_hoe  = 1'b0;
            if (is_read) begin
              next_result = rx;
              ev[cesa_pkg::INT_RD_DONE] = 1'b1;
            end else begin
              ev[cesa_pkg::INT_CLR_DONE] = 1'b1;
            end
          end else begin
            // release before turnaround, keep released through idle clocks
            next_hoe = nb < (is_read ? 7'(cesa_pkg::RD_HDR_LEN) : 7'(cesa_pkg::CLR_HDR_LEN));
            next_hdo = hdr[HW];
            next_hdr = {hdr[HW-1:0], 1'b0};
          end
        end
      end
    end
    if (reg_wr && reg_addr == cesa_pkg::REG_INT_MASK) begin
      next_int_mask = reg_wdata[1:0];
    end
    // a new event wins over a write-one clear in the same cycle
    next_int_stat = int_stat | ev;
    if (reg_wr && reg_addr == cesa_pkg::REG_INT_STAT) begin
      next_int_stat = (int_stat & ~reg_wdata[1:0]) | ev;
    end
    if (reg_rd) begin
      case (reg_addr)
        cesa_pkg::REG_CMD:      next_reg_rdata = cmd;
        cesa_pkg::REG_STATUS:   next_reg_rdata = {31'h0, busy};
        cesa_pkg::REG_RESULT:   next_reg_rdata = result;
        cesa_pkg::REG_INT_STAT: next_reg_rdata = {30'h0, int_stat};
        cesa_pkg::REG_INT_MASK: next_reg_rdata = {30'h0, int_mask};
        default:                next_reg_rdata = '0;
      endcase
    end
    next_irq = |(int_stat & int_mask);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dat_sync  <= 2'h3;
      div       <= '0;
      sck       <= 1'b0;
      sel       <= 1'b1;
      hdo       <= 1'b0;
      hoe       <= 1'b0;
      busy      <= 1'b0;
      is_read   <= 1'b0;
      bitn      <= '0;
      hdr       <= '0;
      rx        <= '0;
      cmd       <= cesa_pkg::CMD_RESET;
      result    <= '0;
      int_stat  <= '0;
      int_mask  <= cesa_pkg::INT_MASK_RESET;
      reg_rdata <= '0;
      irq       <= 1'b0;
    end else if (ce) begin
      dat_sync  <= next_dat_sync;
      div       <= next_div;
      sck       <= next_sck;
      sel       <= next_sel;
      hdo       <= next_hdo;
      hoe       <= next_hoe;
      busy      <= next_busy;
      is_read   <= next_is_read;
      bitn      <= next_bitn;
      hdr       <= next_hdr;
      rx        <= next_rx;
      cmd       <= next_cmd;
      result    <= next_result;
      int_stat  <= next_int_stat;
      int_mask  <= next_int_mask;
      reg_rdata <= next_reg_rdata;
      irq       <= next_irq;
    end
  end

  assign link.serial_port_clock  = sck;
  assign link.serial_port_select = sel;
  assign link.host_data_out      = hdo;
  assign link.host_data_oe       = hoe;
endmodule

/* File: verif/cesa_checker.sv */
// concurrent checks on the serial link between host end and device end
`timescale 1ns/100ps
module cesa_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic serial_port_clock,
  input wire logic serial_port_select,
  input wire logic host_data_out,
  input wire logic host_data_oe,
  input wire logic dev_data_out,
  input wire logic dev_data_oe,
  input wire logic serial_port_data_line
);
  logic       sck_q;
  logic [6:0] rise_cnt;

  // serial clock rises seen within the current frame
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_q    <= 1'b0;
      rise_cnt <= 7'h00;
    end else begin
      sck_q <= serial_port_clock;
      if (serial_port_select)
        rise_cnt <= 7'h00;
      else if (serial_port_clock && !sck_q)
        rise_cnt <= rise_cnt + 7'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sel_release_a: assert property (serial_port_select |-> !dev_data_oe && !host_data_oe)
    else $error("line driven while deselected");
  sck_idle_a: assert property (serial_port_select |-> !serial_port_clock)
    else $error("serial clock runs while deselected");
  one_driver_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the line");
  sck_half_a: assert property ($rose(serial_port_clock) |->
                               serial_port_clock[*4] ##1 !serial_port_clock)
    else $error("serial clock high phase not four cycles");
  dev_change_a: assert property (dev_data_oe && $changed(dev_data_out) |-> serial_port_clock)
    else $error("device data changed in low phase");
  host_hold_a: assert property (host_data_oe && serial_port_clock |-> $stable(host_data_out))
    else $error("host data changed in high phase");
  ta_zero_a: assert property ($rose(dev_data_oe) |-> !dev_data_out && rise_cnt == 7'h2D)
    else $error("device takeover not a zero in turnaround");
  dev_stop_a: assert property ($fell(dev_data_oe) |-> rise_cnt == 7'h4E)
    else $error("device drive not 32 data bits long");
  preamble_a: assert property (host_data_oe && $fell(host_data_out) && rise_cnt <= 7'h20 |->
                               rise_cnt == 7'h20)
    else $error("preamble shorter than 32 ones");
  host_release_a: assert property ($fell(host_data_oe) |-> rise_cnt inside {7'h2C, 7'h2E})
    else $error("host releases line at wrong bit");
  frame_len_a: assert property ($rose(serial_port_select) |-> rise_cnt inside {7'h50, 7'h30})
    else $error("frame end without idle clocks");

  cover property ($rose(dev_data_oe));
  cover property ($rose(serial_port_select) && rise_cnt == 7'h30);
  cover property ($rose(serial_port_select) && rise_cnt == 7'h50);
endmodule

/* File: verif/testbench.sv */
// self-checking bench: host end and device end joined by the serial link
`timescale 1ns/100ps
module testbench;
  logic        clock;
  logic        resetn;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic [1:0]  strap;
  logic [1:0]  mask;
  logic [31:0] key;
  logic [31:0] cnt_data;
  logic [15:0] mem_hi;
  logic [15:0] mem_lo;
  logic [5:0]  col_ev;
  logic [5:0]  err_ev;
  logic [5:0]  col_ovf;
  logic [5:0]  err_ovf;
  logic [6:0]  cnt_addr;
  logic [6:0]  mem_addr_hi;
  logic [6:0]  mem_addr_lo;
  logic [6:0]  clr_index;
  logic [6:0]  got_idx;
  logic        rd_strobe;
  logic        clr_req;
  logic        clr_all;
  logic        got_all;
  logic        sck_q;
  logic [79:0] frame_bits;
  int          nclr;
  int          nrd;
  int          mismatches;
  int          compares;

  cesa_link_if link ();

  cesa_host_end i_cesa_host_end (.clock(clock), .resetn(resetn), .ce(1'b1), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  cesa_dev_end i_cesa_dev_end (.clock(clock), .resetn(resetn), .ce(1'b1), .link(link),
    .strapped_chip_address(strap), .cnt_data(cnt_data), .mem_data_hi(mem_hi),
    .mem_data_lo(mem_lo), .col_ovf_event(col_ev), .err_ovf_event(err_ev),
    .cnt_addr(cnt_addr), .mem_addr_hi(mem_addr_hi), .mem_addr_lo(mem_addr_lo),
    .rd_strobe(rd_strobe), .clr_req(clr_req), .clr_all(clr_all), .clr_index(clr_index),
    .col_ovf(col_ovf), .err_ovf(err_ovf));

  cesa_checker i_cesa_checker (.clock(clock), .resetn(resetn),
    .serial_port_clock(link.serial_port_clock), .serial_port_select(link.serial_port_select),
    .host_data_out(link.host_data_out), .host_data_oe(link.host_data_oe),
    .dev_data_out(link.dev_data_out), .dev_data_oe(link.dev_data_oe),
    .serial_port_data_line(link.serial_port_data_line));

  function automatic logic [31:0] cnt_word(input logic [6:0] a);
    return key ^ {a, 25'h0} ^ {25'h0, a};
  endfunction

  function automatic logic [15:0] mem_word(input logic [6:0] a);
    return {key[15:7], a};
  endfunction

  // counter and memory source, wire sampler and clear-request recorder
  always @(posedge clock) begin
    sck_q <= link.serial_port_clock;
    if (link.serial_port_clock && !sck_q && !link.serial_port_select)
      frame_bits <= {frame_bits[78:0], link.serial_port_data_line};
    if (rd_strobe)
      nrd <= nrd + 1;
    if (clr_req) begin
      nclr <= nclr + 1;
      got_all <= clr_all;
      got_idx <= clr_index;
    end
    cnt_data <= cnt_word(cnt_addr);
    mem_hi <= mem_word(mem_addr_hi);
    mem_lo <= mem_word(mem_addr_lo);
  end

  task automatic chk_word(input string what, input logic [79:0] exp, input logic [79:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic run_cmd(input logic [31:0] cmd);
    logic [31:0] s;
    mask = 2'($urandom);
    key = $urandom;
    wr(cesa_pkg::REG_INT_MASK, {30'h0, mask});
    wr(cesa_pkg::REG_CMD, cmd);
    s = 32'h1;
    while (s[0] !== 1'b0)
      rd(cesa_pkg::REG_STATUS, s);
  endtask

  task automatic check_int(input int bitn);
    logic [31:0] got;
    rd(cesa_pkg::REG_INT_STAT, got);
    chk_word("int status", 32'h1 << bitn, got);
    chk_bit("irq", mask[bitn], irq);
    wr(cesa_pkg::REG_INT_STAT, got);
    @(posedge clock);
    #1 chk_bit("irq cleared", 1'b0, irq);
  endtask

  task automatic do_read(input logic sel, input logic [6:0] a);
    logic [31:0] exp;
    logic [31:0] got;
    int          n0;
    n0 = nrd;
    run_cmd({24'h0, sel, a});
    exp = sel ? cnt_word(a) : a[0] ? {mem_word(a), mem_word(a - 7'h01)}
                                   : {mem_word(a + 7'h01), mem_word(a)};
    rd(cesa_pkg::REG_RESULT, got);
    chk_word("result", exp, got);
    chk_word("read frame", {32'hFFFFFFFF, 4'h6, sel, a, 2'h2, exp, 2'h3}, frame_bits);
    chk_word("read strobe", n0 + 1, nrd);
    check_int(0);
    $display("read test done sel %b addr %h", sel, a);
  endtask

  task automatic do_clear(input logic [1:0] dev, input logic typ, input logic [6:0] idx);
    int n0;
    n0 = nclr;
    run_cmd({15'h0, 1'b1, 6'h0, dev, typ, idx});
    chk_word("clear frame", {32'hFFFFFFFF, 4'h5, dev, typ, idx, 2'h3}, frame_bits[47:0]);
    chk_word("clear count", (dev == strap) ? n0 + 1 : n0, nclr);
    if (dev == strap) begin
      chk_bit("clear type", typ, got_all);
      chk_word("clear index", idx, got_idx);
    end
    check_int(1);
    $display("clear test done dev %h type %b index %h", dev, typ, idx);
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    results();
  end

  initial begin
    logic [31:0] got;
    logic [7:0]  corner [4];
    int          p;
    corner = '{8'hFF, 8'h00, 8'h03, 8'h7E};
    resetn = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    col_ev = 6'h00;
    err_ev = 6'h00;
    key = 32'h0;
    mask = 2'h0;
    void'($urandom(32'h658c1f64));
    strap = 2'($urandom);
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk_word("overflow flags", 12'h000, {col_ovf, err_ovf});
    rd(cesa_pkg::REG_INT_MASK, got);
    chk_word("mask reset", 32'h0, got);
    rd(5'h14, got);
    chk_word("unmapped read", 32'h0, got);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      got = (i < 4) ? {24'h0, corner[i]} : $urandom;
      do_read(got[7], got[6:0]);
    end
    for (int i = 0; i < 4; i++)
      do_clear(i[1] ? strap ^ 2'h1 : strap, i[0], 7'($urandom));
    p = $urandom % 6;
    @(posedge clock);
    col_ev <= 6'h01 << p;
    err_ev <= 6'h01 << p;
    @(posedge clock);
    col_ev <= 6'h00;
    err_ev <= 6'h00;
    @(posedge clock);
    #1 chk_word("overflow set", {6'h01 << p, 6'h01 << p}, {col_ovf, err_ovf});
    do_clear(strap, 1'b1, 7'(p));
    chk_word("overflow cleared", 12'h000, {col_ovf, err_ovf});
    results();
  end

  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
endmodule
